// ==== hdl/osd_core.sv ====
// serial control and diagnostic feedback of an eight channel low-side switch
// Operation
// R1 - fault pin pulls low on any channel error
// R2 - faults latched in diagnosis register until cleared
// R3 - new error overwrites older channel report
// R4 - serial output high impedance while select high
// R5 - diagnostic bits shift out while select low
// R6 - select rising edge clears error registers
// R7 - two bits per channel, HH means ok
// R8 - HL reports active current limiting
// R9 - LH reports open load
// R10 - LL reports short to ground
// R11 - host repeats frame after settling to read
// R12 - control FF accepts data byte as outputs
// R13 - channels one to four ANDed with inputs
// R14 - any nonzero control byte is a write
// R15 - control 00 discards data, outputs unchanged
// R16 - new outputs applied at select rising edge
// R17 - only exactly sixteen clocks frames accepted
// R18 - sample falling edge, shift rising, msb first
// R19 - select falling edge loads diagnosis into shifter
// R20 - reset pin clears shifter, outputs off
// R21 - fault pin released once clear and fault free
// R22 - channel eight code on top bits
`timescale 1ns/10ps
module osd_core
	import osd_pkg::*;
(
	// clock and synchronous reset
	input  wire logic                    mclk,
	input  wire logic                    reset,
	// active low reset pin from outside
	input  wire logic                    rst_pin_n,
	// serial link pins
	input  wire osd_pkg::osd_link_t      link,
	output logic                         sdo_o,
	output logic                         sdo_oe,
	// parallel inputs and polarity select
	input  wire logic [3:0]              par_in,
	input  wire logic                    par_high_active,
	// fault detector levels per channel
	input  wire osd_pkg::osd_fault_t [7:0] fault_det,
	// power outputs and fault flag
	output logic [7:0]                   chan_on,
	output logic                         fault_o,
	output logic                         fault_oe
);
	import osd_pkg::*;

	// ==========================================
	// input synchronisation
	osd_link_t link_s;
	logic      rstp_n_s;
	logic [3:0] par_s;
	logic      prg_s;
	osd_fault_t [7:0] fdet_s;

	osd_sync #(.W(3), .INIT(3'h4)) u_link (.mclk(mclk), .reset(reset), .din(link), .dout(link_s));
	osd_sync #(.W(1), .INIT(1'h1)) u_rstp (.mclk(mclk), .reset(reset), .din(rst_pin_n), .dout(rstp_n_s));
	osd_sync #(.W(5), .INIT(5'h10)) u_par (.mclk(mclk), .reset(reset),
		.din({par_high_active, par_in}), .dout({prg_s, par_s}));
	osd_sync #(.W(24), .INIT(24'h0)) u_fdet (.mclk(mclk), .reset(reset), .din(fault_det), .dout(fdet_s));

	// ==========================================
	// edge detection on the synchronised link
	logic cs_d_r;
	logic sclk_d_r;
	always_ff @(posedge mclk) begin
		if (reset) begin
			cs_d_r   <= 1'b1;
			sclk_d_r <= 1'b0;
		end else begin
			cs_d_r   <= link_s.cs_n;
			sclk_d_r <= link_s.sclk;
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic sck_fall;
	logic sck_rise;
	logic sel;
	assign cs_fall  = cs_d_r & ~link_s.cs_n;
	assign cs_rise  = ~cs_d_r & link_s.cs_n;
	assign sel      = ~link_s.cs_n;
	assign sck_fall = sel & sclk_d_r & ~link_s.sclk;
	assign sck_rise = sel & ~sclk_d_r & link_s.sclk;

	// ==========================================
	// fault encoding; priority only matters if detectors overlap
	function automatic logic [1:0] enc_fault(input osd_fault_t f);
		if (f.short_gnd)      enc_fault = OSD_CODE_SGND; // R10
		else if (f.ilim)      enc_fault = OSD_CODE_ILIM; // R8
		else if (f.open_load) enc_fault = OSD_CODE_OPEN; // R9
		else                  enc_fault = OSD_CODE_OK;   // R7
	endfunction

	// ==========================================
	// diagnosis register: latch faults, newest wins, clear at frame end
	logic [15:0] diag_r;
	genvar gi;
	generate
		for (gi = 0; gi < OSD_CHANNELS; gi++) begin : g_diag
			logic [1:0] code;
			logic [1:0] code_r;
			assign code = enc_fault(fdet_s[gi]);
			// each channel owns its flops, so the packed vector never has two process writers
			always_ff @(posedge mclk) begin
				if (reset || !rstp_n_s) begin
					code_r <= OSD_CODE_OK;
				end else if (code != OSD_CODE_OK) begin
					// set beats the clear of the same cycle
					code_r <= code; // R2 R3
				end else if (cs_rise) begin
					code_r <= OSD_CODE_OK; // R6
				end
			end
			assign diag_r[2*gi+1:2*gi] = code_r; // R22
		end
	endgenerate

	// ==========================================
	// shift register and clock counter
	logic [15:0] shift_r;
	logic [4:0]  cnt_r;
	logic        ovf_r;
	always_ff @(posedge mclk) begin
		if (reset || !rstp_n_s) begin
			shift_r <= OSD_DIAG_RST; // R20
			cnt_r   <= 5'h00;
			ovf_r   <= 1'b0;
		end else if (cs_fall) begin
			shift_r <= diag_r; // R19
			cnt_r   <= 5'h00;
			ovf_r   <= 1'b0;
		end else if (sck_fall) begin
			// extra clocks set the overrun flag instead of wrapping the count
			shift_r <= {shift_r[14:0], link_s.sdi}; // R18
			if (cnt_r == OSD_FRAME_LEN)
				ovf_r <= 1'b1; // R17
			else
				cnt_r <= cnt_r + 5'h01;
		end
	end

	// output bit changes on rising edge, msb first
	// the host should take each bit at the following falling edge; sync latency
	// means sclk must stay high for at least three mclk periods
	logic sdo_r;
	always_ff @(posedge mclk) begin
		if (reset || !rstp_n_s) begin
			sdo_r <= 1'b0;
		end else if (cs_fall) begin
			sdo_r <= diag_r[15];
		end else if (sck_rise) begin
			sdo_r <= shift_r[15]; // R5 R18
		end
	end
	assign sdo_o  = sdo_r;
	assign sdo_oe = sel; // R4

	// ==========================================
	// output latches, updated only on an accepted frame end
	logic [7:0] latch_r;
	logic       frame_ok;
	assign frame_ok = cs_rise && cnt_r == OSD_FRAME_LEN && !ovf_r; // R17
	always_ff @(posedge mclk) begin
		if (reset || !rstp_n_s) begin
			latch_r <= OSD_OUT_RST; // R20
		end else if (frame_ok && shift_r[15:8] != OSD_CTRL_DIAG) begin
			// FF and every other nonzero control byte write; 00 keeps state
			latch_r <= shift_r[7:0]; // R12 R14 R15 R16
		end
	end

	// parallel inputs gate channels one to four
	logic [3:0] par_act;
	assign par_act = prg_s ? par_s : ~par_s;
	always_ff @(posedge mclk) begin
		if (reset || !rstp_n_s)
			chan_on <= OSD_OUT_RST; // R20
		else
			chan_on <= {latch_r[7:4], latch_r[3:0] & par_act}; // R13
	end

	// ==========================================
	// open drain fault flag: pull low while any code is a fault
	assign fault_o  = 1'b0;
	assign fault_oe = (diag_r != OSD_DIAG_RST); // R1 R21

	// ==========================================
	// checks
	a_sdo_tristate: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		link_s.cs_n |-> !sdo_oe && $stable(sdo_o)) else $error("sdo active while deselected"); // R4
	a_fault_flag: assert property (@(posedge mclk) disable iff (reset)
		(enc_fault(fdet_s[0]) != OSD_CODE_OK) |=> fault_oe) else $error("fault not flagged"); // R1
	a_diag_hold: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		(diag_r[1:0] != OSD_CODE_OK && !cs_rise) |=> diag_r[1:0] != OSD_CODE_OK) else $error("fault lost"); // R2
	a_diag_clear: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		(cs_rise && fdet_s == '0) |=> diag_r == OSD_DIAG_RST) else $error("clear missed"); // R6
	a_diag_load: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		cs_fall |=> shift_r == $past(diag_r)) else $error("load missed"); // R19
	a_write_ok: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		(frame_ok && shift_r[15:8] != OSD_CTRL_DIAG) |=> latch_r == $past(shift_r[7:0])) else $error("write lost"); // R14
	a_diag_only: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		(cs_rise && shift_r[15:8] == OSD_CTRL_DIAG) |=> $stable(latch_r)) else $error("outputs changed"); // R15
	a_bad_count: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		(!cs_rise || cnt_r != OSD_FRAME_LEN || ovf_r) |=> $stable(latch_r)) else $error("bad frame taken"); // R17
	a_par_gate: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		!latch_r[0] |=> !chan_on[0]) else $error("channel on without bit"); // R13
	a_rst_pin: assert property (@(posedge mclk) disable iff (reset)
		!rstp_n_s |=> chan_on == OSD_OUT_RST && shift_r == OSD_DIAG_RST) else $error("reset pin ignored"); // R20

	// frame handling, fault flag set and release, and parallel input gating
	a_apply_end: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		!cs_rise |=> $stable(latch_r)) else $error("outputs moved mid frame"); // R16
	a_shift_in: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		sck_fall |=> shift_r[0] == $past(link_s.sdi)) else $error("serial bit not taken"); // R18
	a_flag_any: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		(fdet_s != '0) |=> fault_oe) else $error("fault on a channel not flagged"); // R1
	a_flag_release: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		(cs_rise && fdet_s == '0) |=> !fault_oe) else $error("fault flag not released"); // R21
	a_par_follow: assert property (@(posedge mclk) disable iff (reset || !rstp_n_s)
		(latch_r[0] && par_act[0]) |=> chan_on[0]) else $error("channel off with bit and input"); // R13
endmodule

// ==== hdl/osd_pkg.sv ====
// shared constants and types for the octal switch serial diagnosis block
package osd_pkg;
	localparam int         OSD_CHANNELS   = 8;
	localparam int         OSD_FRAME_BITS = 16;
	localparam logic [4:0] OSD_FRAME_LEN  = 5'h10;
	localparam logic [7:0] OSD_CTRL_DIAG  = 8'h00;
	localparam logic [7:0] OSD_CTRL_WRITE = 8'hff;
	localparam logic [7:0] OSD_OUT_RST    = 8'h00;
	localparam logic [1:0] OSD_CODE_OK    = 2'h3;
	localparam logic [1:0] OSD_CODE_ILIM  = 2'h2;
	localparam logic [1:0] OSD_CODE_OPEN  = 2'h1;
	localparam logic [1:0] OSD_CODE_SGND  = 2'h0;
	localparam logic [15:0] OSD_DIAG_RST  = 16'hffff;

	// raw fault detector levels of one channel
	typedef struct packed {
		logic ilim;
		logic open_load;
		logic short_gnd;
	} osd_fault_t;

	// pins of the serial link as seen inside the block
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic sdi;
	} osd_link_t;
endpackage

// ==== hdl/osd_sync.sv ====
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module osd_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         reset,
	// levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;

	// first stage is read only by the second stage
	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_r <= INIT;
			dout   <= INIT;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule

// ==== tb/osd_core_tb.sv ====
// self-checking bench of the octal switch serial diagnosis core
`timescale 1ns/10ps
module osd_core_tb;
	import osd_pkg::*;
	logic             mclk = 1'b0;
	logic             reset = 1'b1;
	logic             rst_pin_n = 1'b1;
	logic [3:0]       par_in = 4'hf;
	logic             par_high_active = 1'b1;
	osd_fault_t [7:0] fd = '0;
	logic             cs_n, sclk, sdi, sdo_o, sdo_oe, fault_o, fault_oe, so;
	logic [7:0]       chan_on;
	logic [15:0]      rx;
	int               mismatches = 0;
	int               n_tests = 0;
	// a released pin shows the inverse of the output flop, never a stale bit
	assign so = sdo_oe ? sdo_o : ~sdo_o;
	always #12.5 mclk = ~mclk;
	osd_host host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .so(so));
	osd_core dut (.mclk(mclk), .reset(reset), .rst_pin_n(rst_pin_n), .link({cs_n, sclk, sdi}),
		.sdo_o(sdo_o), .sdo_oe(sdo_oe), .par_in(par_in), .par_high_active(par_high_active),
		.fault_det(fd), .chan_on(chan_on), .fault_o(fault_o), .fault_oe(fault_oe));
	// compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one frame of n clocks, then the outputs are compared
	task automatic wr(input logic [15:0] tx, input logic [7:0] exp, input int n = 16);
		host.frame(n, tx, rx);
		repeat (8) @(negedge mclk);
		chk({8'h00, chan_on}, {8'h00, exp});
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// watchdog: all tests need well under 4000 cycles
	initial begin
		repeat (40000) @(posedge mclk);
		mismatches++;
		complete_run();
	end
	// main sequence
	initial begin
		repeat (6) @(negedge mclk);
		reset = 1'b0;
		repeat (4) @(negedge mclk);
		chk({15'h0, sdo_oe}, 16'h0000);
		wr(16'hffa5, 8'ha5);
		par_in = 4'h3;
		wr(16'hffa5, 8'ha1);
		par_high_active = 1'b0;
		par_in = 4'hc;
		wr(16'hffa5, 8'ha1);
		par_in = 4'h0;
		wr(16'h423c, 8'h3c);
		wr(16'h00ff, 8'h3c);
		wr(16'hffc3, 8'h3c, 15);
		wr(16'hffc3, 8'h3c, 17);
		$display("test control byte done");
		fd[0] = 3'b100;
		fd[1] = 3'b100;
		fd[7] = 3'b001;
		repeat (6) @(negedge mclk);
		chk({15'h0, fault_oe}, 16'h0001);
		chk({15'h0, fault_o}, 16'h0000);
		fd[0] = 3'b010;
		fd[2] = 3'b010;
		fd[7] = 3'b000;
		repeat (6) @(negedge mclk);
		chk({15'h0, fault_oe}, 16'h0001);
		host.frame(16, 16'h0000, rx);
		chk(rx, 16'h3fd9);
		fd = '0;
		repeat (6) @(negedge mclk);
		host.frame(16, 16'h0000, rx);
		#2000;
		host.frame(16, 16'h0000, rx);
		chk(rx, 16'hffff);
		chk({15'h0, fault_oe}, 16'h0000);
		$display("test diagnosis done");
		rst_pin_n = 1'b0;
		repeat (6) @(negedge mclk);
		chk({8'h00, chan_on}, 16'h0000);
		$display("test reset pin done");
		complete_run();
	end
endmodule

// ==== tb/osd_host.sv ====
// host side serial master model driving the link pins
`timescale 1ns/10ps
module osd_host (
	// link pins
	output logic      cs_n,
	output logic      sclk,
	output logic      sdi,
	input  wire logic so
);
	// idle levels: select high, clock standing low
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi  = 1'b0;
	end
	// one frame of n clocks; sdi moves well after the fall so the device never sees a race
	task automatic frame(input int n, input logic [15:0] tx, output logic [15:0] rx);
		cs_n = 1'b0;
		#400;
		for (int i = 0; i < n; i++) begin
			sdi = tx[15 - (i % 16)];
			#100;
			sclk = 1'b1;
			#100;
			// the device moves so a few clocks after the rise, so take it just before the fall
			rx = {rx[14:0], so};
			sclk = 1'b0;
			#50;
		end
		#350;
		cs_n = 1'b1;
		sdi  = ~sdi;
		#400;
	endtask
endmodule
